// File: rtl/mps_cfg.svh
/*
 * constants of the multiphase pwm sequencer: widths, counts, reset values.
 * assumes it is included by bare name from rtl/ and by nothing else.
 */
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

// ************************************************************
// widths
// ************************************************************
`define MPS_NCH 3
`define MPS_CUR_W 12
`define MPS_CORR_W 14
`define MPS_CNT_W 19
`define MPS_SIXTH_W 16

// ************************************************************
// timing counts, in block clocks (100 mhz, 10 ns)
// ************************************************************
`define MPS_CLK_PERIOD_NS 10
`define MPS_SIXTHS 19'h6
`define MPS_POS2_3PH 19'h2
`define MPS_POS2_2PH 19'h3
`define MPS_POS3_3PH 19'h4
`define MPS_SIXTH_MIN 16'h1
`define MPS_STRAP_CYC 2'h3
`define MPS_FILT_SHIFT 2

// ************************************************************
// reset values
// ************************************************************
`define MPS_CNT_RST 19'h0
`define MPS_SIXTH_RST 16'h1
`define MPS_CUR_RST 12'h0
`define MPS_CORR_RST 16'h0

`endif

// File: rtl/mps_pkg.sv
/*
 * types shared by the sequencer and its balance loop.
 * assumes mps_cfg.svh is reachable by bare name.
 */
`include "mps_cfg.svh"

package mps_pkg;

    // ************************************************************
    // types
    // ************************************************************
    // sequencer state: strap read, then running
    typedef enum logic [0:0] {
        ST_STRAP = 1'b0,
        ST_RUN = 1'b1
    } mps_state_e;

    // one current word per channel, channel 1 at index 0
    typedef struct packed {
        logic [`MPS_NCH-1:0][`MPS_CUR_W-1:0] ch;
    } mps_cur_s;

    // signed balance correction per channel
    typedef struct packed {
        logic [`MPS_NCH-1:0][`MPS_CORR_W-1:0] ch;
    } mps_corr_s;

endpackage

// File: rtl/mps_phase.sv
/*
 * one phase channel: pulse output, forced off time, sample window, hold.
 * assumes term_i is a one-cycle pulse from the sequencer, and that
 * width_cmd_i is the modified error level expressed in block clocks.
 */
`include "mps_cfg.svh"

module mps_phase (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic active_i,
    input wire logic term_i,
    input wire logic [`MPS_SIXTH_W-1:0] sixth_i,
    input wire logic [`MPS_CNT_W-1:0] period_i,
    input wire logic [`MPS_CNT_W-1:0] width_cmd_i,
    input wire logic [`MPS_CUR_W-1:0] sense_i,
    output logic pulse_o,
    output logic window_o,
    output logic [`MPS_CUR_W-1:0] held_o,
    output logic held_upd_o
);
    logic [`MPS_CNT_W-1:0] elapsed_q, elapsed_d; // clocks since fall
    logic [`MPS_CNT_W-1:0] sixth_w, third_w;
    logic pulse_q, pulse_d, window_q, window_d, upd_q, upd_d;
    logic [`MPS_CUR_W-1:0] held_q, held_d;

    assign sixth_w = `MPS_CNT_W'(sixth_i);
    assign third_w = sixth_w + sixth_w;

    // ************************************************************
    // next state of the channel
    // ************************************************************
    always_comb
    begin
        elapsed_d = elapsed_q;
        pulse_d = pulse_q;
        held_d = held_q;
        upd_d = 1'b0;
        if (!active_i)
        begin
            // idle channel: parked low, nothing held
            elapsed_d = `MPS_CNT_RST;
            pulse_d = 1'b0;
            held_d = `MPS_CUR_RST;
        end
        else if (term_i)
        begin
            // termination always wins over a rise
            elapsed_d = `MPS_CNT_RST;
            pulse_d = 1'b0;
        end
        else
        begin
            if (elapsed_q < period_i)
                elapsed_d = elapsed_q + `MPS_CNT_W'(1);
            // rise only after the off third, once the ramp is crossed
            if (elapsed_q >= third_w && (period_i - elapsed_q) <= width_cmd_i)
                pulse_d = 1'b1;
            // last window cycle: capture and hold for a whole period
            if (elapsed_q == third_w - `MPS_CNT_W'(1))
            begin
                held_d = sense_i;
                upd_d = 1'b1;
            end
        end
        // window spans the second sixth after the fall
        window_d = active_i && !term_i && elapsed_d >= sixth_w && elapsed_d < third_w;
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            elapsed_q <= `MPS_CNT_RST;
            pulse_q <= 1'b0;
            window_q <= 1'b0;
            held_q <= `MPS_CUR_RST;
            upd_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            elapsed_q <= elapsed_d;
            pulse_q <= pulse_d;
            window_q <= window_d;
            held_q <= held_d;
            upd_q <= upd_d;
        end
    end

    assign pulse_o = pulse_q;
    assign window_o = window_q;
    assign held_o = held_q;
    assign held_upd_o = upd_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_i iff clk_en_i); endclocking
    default disable iff (!rstn_i);

    property p_win_open;
        $rose(window_q) |-> elapsed_q == sixth_w;
    endproperty
    a_win_open: assert property (p_win_open) else $error("window opened off the sixth");

    property p_win_close;
        $fell(window_q) && active_i && !$past(term_i) |-> elapsed_q == third_w;
    endproperty
    a_win_close: assert property (p_win_close) else $error("window length wrong");

    property p_hold;
        !upd_q && active_i |-> $stable(held_q);
    endproperty
    a_hold: assert property (p_hold) else $error("held sample moved");

    property p_rise;
        $rose(pulse_q) |-> $past(elapsed_q) >= third_w
            && $past(period_i - elapsed_q) <= $past(width_cmd_i);
    endproperty
    a_rise: assert property (p_rise) else $error("pulse rose early");
endmodule

// File: rtl/mps_balance.sv
/*
 * cycle average of the held channel currents and filtered balance errors.
 * assumes upd_i pulses once per switching cycle and samples are unsigned.
 */
`include "mps_cfg.svh"

module mps_balance (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic upd_i,
    input wire logic two_phase_i,
    input wire mps_pkg::mps_cur_s held_i,
    output logic [`MPS_CUR_W-1:0] avg_o,
    output mps_pkg::mps_corr_s corr_o
);
    logic [`MPS_CUR_W+1:0] sum_w; // sum of active samples
    logic [`MPS_CUR_W-1:0] avg_q, avg_d;
    logic signed [15:0] acc_q [`MPS_NCH];
    logic signed [15:0] acc_d [`MPS_NCH];
    logic signed [15:0] err_w [`MPS_NCH];

    // ************************************************************
    // average and error filter
    // ************************************************************
    always_comb
    begin
        sum_w = (`MPS_CUR_W+2)'(held_i.ch[0]) + (`MPS_CUR_W+2)'(held_i.ch[1]);
        if (!two_phase_i)
            sum_w = sum_w + (`MPS_CUR_W+2)'(held_i.ch[2]);
        // floor divide by the active count
        if (two_phase_i)
            avg_d = `MPS_CUR_W'(sum_w >> 1);
        else
            avg_d = `MPS_CUR_W'(sum_w / (`MPS_CUR_W+2)'(3));
        if (!upd_i)
            avg_d = avg_q;
        for (int c = 0; c < `MPS_NCH; c++)
        begin
            // channel above average gets a positive error
            err_w[c] = $signed(16'(held_i.ch[c])) - $signed(16'(avg_q));
            acc_d[c] = acc_q[c];
            if (upd_i)
                acc_d[c] = acc_q[c] + ((err_w[c] - acc_q[c]) >>> `MPS_FILT_SHIFT);
            if (two_phase_i && c == `MPS_NCH - 1)
                acc_d[c] = `MPS_CORR_RST;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            avg_q <= `MPS_CUR_RST;
            for (int c = 0; c < `MPS_NCH; c++)
                acc_q[c] <= `MPS_CORR_RST;
        end
        else if (clk_en_i)
        begin
            avg_q <= avg_d;
            for (int c = 0; c < `MPS_NCH; c++)
                acc_q[c] <= acc_d[c];
        end
    end

    assign avg_o = avg_q;
    always_comb
    begin
        for (int c = 0; c < `MPS_NCH; c++)
            corr_o.ch[c] = `MPS_CORR_W'(acc_q[c]);
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_i iff clk_en_i); endclocking
    default disable iff (!rstn_i);

    // three-phase: the average is the floor of the sum over three
    property p_avg;
        upd_i && !two_phase_i |=> 3 * avg_q <= $past(sum_w)
            && $past(sum_w) < 3 * avg_q + 3;
    endproperty
    a_avg: assert property (p_avg) else $error("average not taken");

    property p_toward;
        upd_i && err_w[0] > acc_q[0] + 16'sh3 |=> acc_q[0] > $past(acc_q[0]);
    endproperty
    a_toward: assert property (p_toward) else $error("filter moved away");
endmodule

// File: rtl/mps_top.sv
/*
 * multiphase pwm sequencer: interleaved phase terminations, forced off
 * time, current sample windows, cycle average and channel balance.
 * assumes: a 100 mhz clock; error level and current samples come from
 * converters clocked by mclk_i; the phase-3 pin is a two-way pin and
 * the board either ties it to the supply or wires it to a driver.
 */
// Notes on behaviour
// - three channels run unless two selected
// - phase-1 fall starts each cycle
// - three-phase: terminations spaced one third apart
// - phase-3 pin tied high selects two-phase, half spacing
// - fallen output stays low one third cycle
// - after off time, rise on ramp crossing
// - high output stays high until termination
// - sample window opens one sixth after fall
// - sample window lasts one sixth of period
// - held sample kept until next sample
// - held samples feed balance, average, overcurrent
// - phase-3 sense idle in two-phase mode
// - average is active sum over active count
// - filtered error trims each channel's width
`include "mps_cfg.svh"

module mps_top (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [`MPS_SIXTH_W-1:0] sixth_len_i,
    input wire logic [`MPS_CUR_W-1:0] error_amp_level_i,
    input wire mps_pkg::mps_cur_s phase_current_sense_i,
    input wire logic [`MPS_CUR_W-1:0] oc_limit_i,
    input wire logic phase3_pulse_in_i,
    output logic phase1_pulse_out_o,
    output logic phase2_pulse_out_o,
    output logic phase3_pulse_out_o,
    output logic phase3_pulse_oe_n_o,
    output logic [`MPS_NCH-1:0] sample_window_o,
    output mps_pkg::mps_cur_s held_current_o,
    output logic [`MPS_CUR_W-1:0] cycle_avg_current_o,
    output logic overcurrent_o,
    output logic two_phase_o
);
    // ************************************************************
    // declarations
    // ************************************************************
    mps_pkg::mps_state_e state_q, state_d; // strap read or running
    logic [1:0] strap_cnt_q, strap_cnt_d; // settle time of the synchroniser
    logic tie_s1_q, tie_s2_q; // phase-3 pin synchroniser
    logic two_phase_q, two_phase_d; // latched channel count strap
    logic [`MPS_SIXTH_W-1:0] sixth_q, sixth_d; // one sixth of the period
    logic [`MPS_CNT_W-1:0] cnt_q, cnt_d; // position in the cycle
    logic [`MPS_CNT_W-1:0] sixth_w, period_w, pos2_w, pos3_w;
    logic run_w; // sequencer is running
    logic [`MPS_NCH-1:0] term_w; // one-cycle termination per channel
    logic [`MPS_NCH-1:0] active_w; // channel in use
    logic [`MPS_NCH-1:0] pulse_w; // registered phase outputs
    logic [`MPS_NCH-1:0] upd_w; // sample just captured
    logic [`MPS_CNT_W-1:0] cmd_w [`MPS_NCH]; // width command, clocks
    mps_pkg::mps_cur_s held_w; // held samples
    mps_pkg::mps_corr_s corr_w; // balance corrections
    logic [`MPS_CUR_W-1:0] avg_w; // cycle average current
    logic oc_q, oc_d; // overcurrent flag
    logic [`MPS_CNT_W-1:0] off1_q, off1_d; // low time of phase 1, for checks

    // ************************************************************
    // strap synchroniser
    // ************************************************************
    // the pin comes from the board, so two flops before any use;
    // only the second flop is read
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tie_s1_q <= 1'b0;
            tie_s2_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            tie_s1_q <= phase3_pulse_in_i;
            tie_s2_q <= tie_s1_q;
        end
    end

    // ************************************************************
    // cycle timing
    // ************************************************************
    // the period is six sixths, so every interleave point is an edge
    assign sixth_w = `MPS_CNT_W'(sixth_q);
    assign period_w = sixth_w * `MPS_SIXTHS;
    assign run_w = (state_q == mps_pkg::ST_RUN);

    // phase-2 point is a half cycle in two-phase, a third otherwise
    assign pos2_w = two_phase_q ? sixth_w * `MPS_POS2_2PH
                                : sixth_w * `MPS_POS2_3PH;
    assign pos3_w = sixth_w * `MPS_POS3_3PH;

    // terminations: phase 1 at the wrap, the others at their points
    always_comb
    begin
        term_w[0] = run_w && cnt_q == `MPS_CNT_RST;
        term_w[1] = run_w && cnt_q == pos2_w;
        term_w[2] = run_w && !two_phase_q && cnt_q == pos3_w;
        // channel 3 only in three-phase operation
        active_w = {run_w && !two_phase_q, run_w, run_w};
    end

    // next state of the sequencer
    always_comb
    begin
        state_d = state_q;
        strap_cnt_d = strap_cnt_q;
        two_phase_d = two_phase_q;
        sixth_d = sixth_q;
        cnt_d = cnt_q;
        unique case (state_q)
            mps_pkg::ST_STRAP:
            begin
                // pin undriven here; wait for the synchroniser
                if (strap_cnt_q == `MPS_STRAP_CYC)
                begin
                    two_phase_d = tie_s2_q;
                    state_d = mps_pkg::ST_RUN;
                    cnt_d = `MPS_CNT_RST;
                    sixth_d = (sixth_len_i == '0) ? `MPS_SIXTH_MIN : sixth_len_i;
                end
                else
                    strap_cnt_d = strap_cnt_q + 2'h1;
            end
            mps_pkg::ST_RUN:
            begin
                // a new length is taken only at a cycle boundary, so a
                // change never splits a cycle between two lengths
                if (cnt_q == period_w - `MPS_CNT_W'(1))
                begin
                    cnt_d = `MPS_CNT_RST;
                    sixth_d = (sixth_len_i == '0) ? `MPS_SIXTH_MIN : sixth_len_i;
                end
                else
                    cnt_d = cnt_q + `MPS_CNT_W'(1);
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= mps_pkg::ST_STRAP;
            strap_cnt_q <= 2'h0;
            two_phase_q <= 1'b0;
            sixth_q <= `MPS_SIXTH_RST;
            cnt_q <= `MPS_CNT_RST;
        end
        else if (clk_en_i)
        begin
            state_q <= state_d;
            strap_cnt_q <= strap_cnt_d;
            two_phase_q <= two_phase_d;
            sixth_q <= sixth_d;
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // phase channels
    // ************************************************************
    // width command is the error level less the channel correction,
    // clamped at zero so an over-correction just skips the pulse
    for (genvar c = 0; c < `MPS_NCH; c++)
    begin : g_ch
        logic signed [`MPS_CORR_W+1:0] mod_w;
        assign mod_w = $signed({4'b0000, error_amp_level_i})
                     - $signed({{2{corr_w.ch[c][`MPS_CORR_W-1]}}, corr_w.ch[c]});
        assign cmd_w[c] = mod_w[`MPS_CORR_W+1] ? '0
                        : `MPS_CNT_W'(mod_w[`MPS_CORR_W:0]);

        mps_phase u_phase (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .clk_en_i(clk_en_i),
            .active_i(active_w[c]),
            .term_i(term_w[c]),
            .sixth_i(sixth_q),
            .period_i(period_w),
            .width_cmd_i(cmd_w[c]),
            .sense_i(phase_current_sense_i.ch[c]),
            .pulse_o(pulse_w[c]),
            .window_o(sample_window_o[c]),
            .held_o(held_w.ch[c]),
            .held_upd_o(upd_w[c])
        );
    end

    // ************************************************************
    // balance and protection
    // ************************************************************
    // held samples feed the average, the balance loop and the
    // overcurrent compare
    mps_balance u_balance (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .upd_i(term_w[0]),
        .two_phase_i(two_phase_q),
        .held_i(held_w),
        .avg_o(avg_w),
        .corr_o(corr_w)
    );

    // overcurrent: any active held sample above the limit
    always_comb
    begin
        oc_d = 1'b0;
        for (int c = 0; c < `MPS_NCH; c++)
            if (active_w[c] && held_w.ch[c] > oc_limit_i)
                oc_d = 1'b1;
        // low time of phase 1, kept only for the checks below
        off1_d = pulse_w[0] ? `MPS_CNT_RST : off1_q + `MPS_CNT_W'(1);
        if (!run_w)
            off1_d = `MPS_CNT_RST;
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            oc_q <= 1'b0;
            off1_q <= `MPS_CNT_RST;
        end
        else if (clk_en_i)
        begin
            oc_q <= oc_d;
            off1_q <= off1_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign phase1_pulse_out_o = pulse_w[0];
    assign phase2_pulse_out_o = pulse_w[1];
    assign phase3_pulse_out_o = pulse_w[2];
    // the pin is released while the strap is read and when tied high
    assign phase3_pulse_oe_n_o = !(run_w && !two_phase_q);
    assign held_current_o = held_w;
    assign cycle_avg_current_o = avg_w;
    assign overcurrent_o = oc_q;
    assign two_phase_o = two_phase_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_i iff clk_en_i); endclocking
    default disable iff (!rstn_i);

    property p_start;
        term_w[0] |=> !phase1_pulse_out_o && cnt_q == 19'h1;
    endproperty
    a_start: assert property (p_start) else $error("cycle start not low");

    property p_ph2_third;
        $fell(phase2_pulse_out_o) && !two_phase_q |-> cnt_q == sixth_w * 19'h2 + 19'h1;
    endproperty
    a_ph2_third: assert property (p_ph2_third) else $error("phase 2 off third");

    property p_ph3_third;
        $fell(phase3_pulse_out_o) && run_w |-> cnt_q == sixth_w * 19'h4 + 19'h1;
    endproperty
    a_ph3_third: assert property (p_ph3_third) else $error("phase 3 off third");

    property p_ph2_half;
        $fell(phase2_pulse_out_o) && two_phase_q |-> cnt_q == sixth_w * 19'h3 + 19'h1;
    endproperty
    a_ph2_half: assert property (p_ph2_half) else $error("phase 2 off half");

    property p_two_idle;
        two_phase_q |-> phase3_pulse_oe_n_o && !phase3_pulse_out_o && !sample_window_o[2];
    endproperty
    a_two_idle: assert property (p_two_idle) else $error("phase 3 active");

    // three-phase: channel 3 is driven and terminates at its own point
    property p_three_run;
        run_w && !two_phase_q && cnt_q == sixth_w * 19'h4
            |=> !phase3_pulse_oe_n_o && !phase3_pulse_out_o;
    endproperty
    a_three_run: assert property (p_three_run) else $error("phase 3 not driven");

    property p_off_time;
        $rose(phase1_pulse_out_o) |-> $past(off1_q) >= sixth_w * 19'h2;
    endproperty
    a_off_time: assert property (p_off_time) else $error("off time short");

    property p_stay_high;
        phase1_pulse_out_o && !term_w[0] |=> phase1_pulse_out_o;
    endproperty
    a_stay_high: assert property (p_stay_high) else $error("pulse dropped early");

    property p_oc;
        run_w && active_w[2] && held_w.ch[2] > oc_limit_i ##1 run_w |-> overcurrent_o;
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent missed");

    property p_period;
        run_w |-> cnt_q < period_w;
    endproperty
    a_period: assert property (p_period) else $error("count past period");

    c_ph3_rise: cover property ($rose(phase3_pulse_out_o));
    c_two_term: cover property (two_phase_q && $fell(phase2_pulse_out_o));
    c_oc: cover property ($rose(overcurrent_o));
    c_win: cover property ($fell(sample_window_o[0]));
endmodule

// File: dv/mps_drv_model.sv
/*
 * switch driver model, one lane per phase.
 * assumes the phase pins are logic levels from the sequencer.
 */
module mps_drv_model (
    input wire logic [2:0] phase_i,
    output logic [2:0] upper_on_o,
    output logic [2:0] lower_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // high input turns on the upper switch, low the synchronous one
    assign upper_on_o = phase_i;
    assign lower_on_o = ~phase_i;
endmodule

// File: dv/multiphase_pwm_sequencer_test.sv
/*
 * self-checking bench of the sequencer top, sixth length fixed at 4.
 * assumes a 100 mhz clock and a strap settle of four enabled clocks.
 */
module multiphase_pwm_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // stimulus and monitors
    // ************************************************************
    localparam int S = 4;
    logic mclk_i, rstn_i, en, strap, pin3, p1, p2, p3, oe_n, two, oc;
    logic [11:0] lvl, oc_lim, avg;
    logic [2:0] win, ph, ph_q, w_q, up, lo;
    mps_pkg::mps_cur_s sense, held;
    int error_cnt, num_checks, cyc, s0, f[3], wr[3], wf[3];
    // released pin: board tie in two-phase, driver pull-down otherwise
    assign pin3 = oe_n ? strap : p3;
    assign ph = {p3, p2, p1};
    mps_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(en),
        .sixth_len_i(16'h4), .error_amp_level_i(lvl), .phase_current_sense_i(sense),
        .oc_limit_i(oc_lim), .phase3_pulse_in_i(pin3), .phase1_pulse_out_o(p1),
        .phase2_pulse_out_o(p2), .phase3_pulse_out_o(p3), .phase3_pulse_oe_n_o(oe_n),
        .sample_window_o(win), .held_current_o(held), .cycle_avg_current_o(avg),
        .overcurrent_o(oc), .two_phase_o(two));
    mps_drv_model u_drv (.phase_i({p3, p2, p1}), .upper_on_o(up), .lower_on_o(lo));
    initial
    begin
        mclk_i = 0;
        forever #5 mclk_i = ~mclk_i;
    end
    // edge times in cycles, taken on the settled falling clock edge
    always @(negedge mclk_i)
    begin
        cyc++;
        ph_q <= ph;
        w_q <= win;
        for (int k = 0; k < 3; k++)
        begin
            if (ph_q[k] && !ph[k]) f[k] = cyc;
            if (!w_q[k] && win[k]) wr[k] = cyc;
            if (w_q[k] && !win[k]) wf[k] = cyc;
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task check(input logic [18:0] seen, input logic [18:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task do_reset(input logic s);
        rstn_i <= 0;
        strap <= s;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1;
        repeat (80) @(posedge mclk_i);
    endtask
    task sync;
        int old;
        old = f[0];
        for (int i = 0; i < 40 && f[0] == old; i++) @(posedge mclk_i);
        s0 = f[0];
    endtask
    task test_three;
        do_reset(0);
        sync();
        check(two, 0, "mode");
        // outputs are read on the falling edge, where they have settled
        repeat (22) @(posedge mclk_i);
        @(negedge mclk_i);
        check(p1, 1, "ph1 high");
        check({up, lo}, 6'h1c, "drv");
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        check(f[1] - s0, 2 * S, "ph2 fall");
        check(f[2] - s0, 4 * S, "ph3 fall");
        check(f[0] - s0, 6 * S, "period");
        for (int k = 1; k < 3; k++)
        begin
            check(wr[k] - f[k], S, "win open");
            check(wf[k] - wr[k], S, "win len");
        end
        for (int k = 0; k < 3; k++) check(held.ch[k], sense.ch[k], "held");
        check(avg, 12'h258, "avg3");
        check(oc, 1, "oc");
        @(posedge mclk_i);
        sense.ch[2] <= 12'h032;
        repeat (14) @(posedge mclk_i);
        @(negedge mclk_i);
        check(held.ch[2], 12'h384, "hold");
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i);
        check(held.ch[2], 12'h032, "resample");
    endtask
    task test_two;
        @(posedge mclk_i);
        sense.ch[2] <= 12'h384;
        do_reset(1);
        sync();
        repeat (26) @(posedge mclk_i);
        @(negedge mclk_i);
        check(two, 1, "strap");
        check(f[1] - s0, 3 * S, "ph2 half");
        check({p3, win[2], oe_n}, 3'h1, "ph3 idle");
        check(held.ch[2], 0, "held3");
        check(avg, 12'h1c2, "avg2");
        check(oc, 0, "no oc");
        // enable low for more than a period: no phase-1 fall may happen
        s0 = f[0];
        @(posedge mclk_i);
        en <= 0;
        repeat (30) @(posedge mclk_i);
        @(negedge mclk_i);
        check(f[0] - s0, 0, "frozen");
        @(posedge mclk_i);
        en <= 1;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        rstn_i = 0;
        en = 1;
        strap = 0;
        // level above the largest correction, so every channel still pulses
        lvl = 12'h190;
        oc_lim = 12'h320;
        sense = {12'h384, 12'h258, 12'h12c};
        test_three();
        test_two();
        print_verdict();
    end
    initial
    begin
        #50us;
        error_cnt++;
        print_verdict();
    end
endmodule
